// ---- verilog/urf_consts.vh ----
`ifndef URF_CONSTS_VH
`define URF_CONSTS_VH

// Register byte addresses
`define URF_ADDR_MASK 12'h068
`define URF_ADDR_DELAY 12'h06C
`define URF_ADDR_LEVEL 12'h070

// Report mask layout
`define URF_BIT_ALWAYS 31
`define URF_BIT_MACRTO 19
`define URF_BIT_RXFRAME 18
`define URF_BIT_TXHALT 17
`define URF_BIT_RXHALT 16
`define URF_BIT_PHY 15
`define URF_BIT_TXERR 14
`define URF_BIT_TXUNDER 13
`define URF_BIT_TXOVER 12
`define URF_BIT_RXDROP 11
`define URF_PIN_HI 10
`define URF_MASK_WMASK 32'h800FFFFF
`define URF_MASK_RESET 32'h00000000

// Short packet delay field
`define URF_DELAY_W 16
`define URF_DELAY_RESET 16'h0800
`define URF_DELAY_STEP_PS 16667

// Level counter fields
`define URF_RDLVL_LO 16
`define URF_RDLVL_W 14
`define URF_WRLVL_W 14

// Clock period
`define URF_CLK_PS 50000

`endif

// ---- verilog/urf_report_level.v ----
module urf_report_level #(
    parameter EVT_W = 20,
    parameter CNT_W = 14
) (
    clk_sys,
    rst_n,
    regAddr,
    regWrData,
    regWr,
    regRd,
    regRdData,
    eventPulse,
    pollTick,
    statusSend,
    statusEvents,
    shortPending,
    shortGo,
    fifoWrWord,
    fifoWrEnd,
    fifoWrRewind,
    fifoRdWord,
    fifoRdEnd,
    fifoRdRewind
);
`include "urf_consts.vh"
    // Clock and synchronous reset
    input wire clk_sys;
    input wire rst_n;
    // Register port, read data one cycle later
    input wire [11:0] regAddr;
    input wire [31:0] regWrData;
    input wire regWr;
    input wire regRd;
    output reg [31:0] regRdData;
    // Event sources and interrupt endpoint slot
    input wire [EVT_W-1:0] eventPulse;
    input wire pollTick;
    output reg statusSend;
    output reg [EVT_W-1:0] statusEvents;
    // Short packet hold-off handshake
    input wire shortPending;
    output reg shortGo;
    // Receive FIFO write side strobes
    input wire fifoWrWord;
    input wire fifoWrEnd;
    input wire fifoWrRewind;
    // Receive FIFO read side strobes
    input wire fifoRdWord;
    input wire fifoRdEnd;
    input wire fifoRdRewind;

    // Delay step to clock cycles, rounded up, at least one
    localparam integer STEP_PS = `URF_DELAY_STEP_PS;
    localparam integer CLK_PS = `URF_CLK_PS;
    localparam integer STEP_CYC_RAW = (STEP_PS + CLK_PS - 1) / CLK_PS;
    localparam integer STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
    // Total wait fits in delay width times step count
    localparam integer WAIT_W = `URF_DELAY_W + 2;
    localparam [WAIT_W-1:0] WAIT_ONE = {{(WAIT_W-1){1'b0}}, 1'b1};
    // Hold-off timer states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_COUNT = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    reg [31:0] maskQ;
    reg [`URF_DELAY_W-1:0] delayQ;
    reg [EVT_W-1:0] pendQ;
    reg [CNT_W-1:0] rdLvlQ;
    reg [CNT_W-1:0] wrLvlQ;
    reg [CNT_W-1:0] wrPktQ;
    reg [CNT_W-1:0] rdPktQ;
    reg [CNT_W-1:0] rdLvlD;
    reg [CNT_W-1:0] wrLvlD;
    reg [WAIT_W-1:0] waitQ;
    reg [2:0] stateQ;
    wire [EVT_W-1:0] enables;
    wire [EVT_W-1:0] gatedEvt;
    wire [WAIT_W-1:0] waitLoad;
    wire [31:0] waitProd;
    wire [CNT_W-1:0] wrPktNext;
    wire [CNT_W-1:0] rdPktNext;
    wire [31:0] maskImage;
    wire [31:0] delayImage;
    wire [31:0] levelImage;
    wire sendNow;
    wire hitMask;
    wire hitDelay;
    // Named report enables, one per mask field
    wire statusPipeAlwaysSend;
    wire macResetTimeoutReportEn;
    wire rxFrameReportEn;
    wire transmitterHaltedReportEn;
    wire receiverHaltedReportEn;
    wire transceiverEventReportEn;
    wire transmitErrorReportEn;
    wire txFifoUnderrunReportEn;
    wire txFifoOverrunReportEn;
    wire droppedFrameReportEn;
    wire [`URF_PIN_HI:0] pinEventReportEn;

    // Mask fields split out by source
    assign statusPipeAlwaysSend = maskQ[`URF_BIT_ALWAYS];
    assign macResetTimeoutReportEn = maskQ[`URF_BIT_MACRTO];
    assign rxFrameReportEn = maskQ[`URF_BIT_RXFRAME];
    assign transmitterHaltedReportEn = maskQ[`URF_BIT_TXHALT];
    assign receiverHaltedReportEn = maskQ[`URF_BIT_RXHALT];
    assign transceiverEventReportEn = maskQ[`URF_BIT_PHY];
    assign transmitErrorReportEn = maskQ[`URF_BIT_TXERR];
    assign txFifoUnderrunReportEn = maskQ[`URF_BIT_TXUNDER];
    assign txFifoOverrunReportEn = maskQ[`URF_BIT_TXOVER];
    assign droppedFrameReportEn = maskQ[`URF_BIT_RXDROP];
    assign pinEventReportEn = maskQ[`URF_PIN_HI:0];

    // Enable vector in event bit order, timeout down to pins
    assign enables = {macResetTimeoutReportEn, rxFrameReportEn,
        transmitterHaltedReportEn, receiverHaltedReportEn,
        transceiverEventReportEn, transmitErrorReportEn, txFifoUnderrunReportEn,
        txFifoOverrunReportEn, droppedFrameReportEn, pinEventReportEn};

    // Address decode for writes
    assign hitMask = (regAddr == `URF_ADDR_MASK);
    assign hitDelay = (regAddr == `URF_ADDR_DELAY);

    // Each source passes only when its enable bit is set
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi = gi + 1) begin : gEvt
            assign gatedEvt[gi] = eventPulse[gi] & enables[gi];
        end
    endgenerate

    // Register writes; reserved bits masked off
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            maskQ <= `URF_MASK_RESET;
            delayQ <= `URF_DELAY_RESET;
        end else if (regWr) begin
            if (hitMask) begin
                maskQ <= regWrData & `URF_MASK_WMASK;
            end
            if (hitDelay) begin
                delayQ <= regWrData[`URF_DELAY_W-1:0];
            end
        end
    end

    // Read images; reserved positions forced to zero
    assign maskImage = maskQ & `URF_MASK_WMASK;
    assign delayImage = {{(32-`URF_DELAY_W){1'b0}}, delayQ};
    assign levelImage = {2'h0, rdLvlQ, 2'h0, wrLvlQ};

    // Read data one cycle after strobe; unmapped reads zero
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdData <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                `URF_ADDR_MASK: regRdData <= maskImage;
                `URF_ADDR_DELAY: regRdData <= delayImage;
                `URF_ADDR_LEVEL: regRdData <= levelImage;
                default: regRdData <= 32'h00000000;
            endcase
        end else begin
            regRdData <= 32'h00000000;
        end
    end

    // Poll slot is used when always-send is on or something is pending
    assign sendNow = pollTick && (statusPipeAlwaysSend || (pendQ != {EVT_W{1'b0}}));

    // Sticky pending events; new event wins over the send clear
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pendQ <= {EVT_W{1'b0}};
            statusSend <= 1'b0;
            statusEvents <= {EVT_W{1'b0}};
        end else begin
            statusSend <= 1'b0;
            if (sendNow) begin
                statusSend <= 1'b1;
                statusEvents <= pendQ;
                pendQ <= gatedEvt;
            end else begin
                pendQ <= pendQ | gatedEvt;
            end
        end
    end

    // Wait length in cycles; product cut to the timer width on purpose
    assign waitProd = delayQ * STEP_CYC;
    assign waitLoad = waitProd[WAIT_W-1:0];

    // Short packet hold-off timer, one-hot states
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stateQ <= ST_IDLE;
            waitQ <= {WAIT_W{1'b0}};
            shortGo <= 1'b0;
        end else begin
            shortGo <= 1'b0;
            case (stateQ)
                ST_IDLE: begin
                    // Load the delay when a short packet shows up
                    if (shortPending) begin
                        waitQ <= waitLoad;
                        if (waitLoad == {WAIT_W{1'b0}}) begin
                            shortGo <= 1'b1;
                            stateQ <= ST_HOLD;
                        end else begin
                            stateQ <= ST_COUNT;
                        end
                    end
                end
                ST_COUNT: begin
                    // Count down; a withdrawn packet aborts the wait
                    if (!shortPending) begin
                        stateQ <= ST_IDLE;
                    end else if (waitQ > WAIT_ONE) begin
                        waitQ <= waitQ - 1'b1;
                    end else begin
                        waitQ <= {WAIT_W{1'b0}};
                        shortGo <= 1'b1;
                        stateQ <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Re-arm only once the pending packet is gone
                    if (!shortPending) begin
                        stateQ <= ST_IDLE;
                    end
                end
                default: begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    // Packet word tallies including a word in this same cycle
    assign wrPktNext = fifoWrWord ? wrPktQ + 1'b1 : wrPktQ;
    assign rdPktNext = fifoRdWord ? rdPktQ + 1'b1 : rdPktQ;

    // Read-side level next value; a write rewind cancels the packet end
    always @* begin
        rdLvlD = rdLvlQ;
        if (fifoWrEnd && !fifoWrRewind) begin
            rdLvlD = rdLvlD + wrPktNext;
        end
        if (fifoRdWord) begin
            rdLvlD = rdLvlD - 1'b1;
        end
        if (fifoRdRewind) begin
            rdLvlD = rdLvlD + rdPktNext;
        end
    end

    // Write-side level next value; a read rewind cancels the packet end
    always @* begin
        wrLvlD = wrLvlQ;
        if (fifoWrWord) begin
            wrLvlD = wrLvlD + 1'b1;
        end
        if (fifoWrRewind) begin
            wrLvlD = wrLvlD - wrPktNext;
        end
        if (fifoRdEnd && !fifoRdRewind) begin
            wrLvlD = wrLvlD - rdPktNext;
        end
    end

    // Level counters; software can only read them
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rdLvlQ <= {CNT_W{1'b0}};
            wrLvlQ <= {CNT_W{1'b0}};
        end else begin
            rdLvlQ <= rdLvlD;
            wrLvlQ <= wrLvlD;
        end
    end

    // Words of the packet now entering the FIFO
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPktQ <= {CNT_W{1'b0}};
        end else if (fifoWrEnd || fifoWrRewind) begin
            wrPktQ <= {CNT_W{1'b0}};
        end else begin
            wrPktQ <= wrPktNext;
        end
    end

    // Words of the packet now leaving the FIFO
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rdPktQ <= {CNT_W{1'b0}};
        end else if (fifoRdEnd || fifoRdRewind) begin
            rdPktQ <= {CNT_W{1'b0}};
        end else begin
            rdPktQ <= rdPktNext;
        end
    end

endmodule

// ---- tb/urf_report_level_properties.sv ----
module urf_report_level_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire [11:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regRdData,
    input wire pollTick,
    input wire statusSend,
    input wire [19:0] statusEvents,
    input wire shortPending,
    input wire shortGo
);
    timeunit 1ns / 1ns;
    logic [31:0] maskQ;
    // Shadow copy of the report mask
    always @(posedge clk_sys) begin
        if (!rst_n) maskQ <= 32'h0;
        else if (regWr && regAddr == 12'h068) maskQ <= regWrData & 32'h800FFFFF;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    send_poll_a: assert property (statusSend |-> $past(pollTick)) else $error("stray send");
    always_on_a: assert property (pollTick && maskQ[31] |=> statusSend) else $error("no send");
    mask_gate_a: assert property (statusSend |-> (statusEvents & ~maskQ[19:0]) == 20'h0)
        else $error("unmasked event");
    empty_send_a: assert property (statusSend && statusEvents == 20'h0 |-> $past(maskQ[31]))
        else $error("empty send");
    go_pend_a: assert property (shortGo |-> $past(shortPending)) else $error("stray go");
    go_pulse_a: assert property (shortGo |=> !shortGo) else $error("long go");
    level_rsvd_a: assert property ($past(regRd) && $past(regAddr) == 12'h070 |->
        (regRdData & 32'hC000C000) == 32'h0) else $error("level reserved");
    mask_echo_a: assert property ($past(regRd) && $past(regAddr) == 12'h068 |->
        regRdData == maskQ) else $error("mask readback");
    cover property (statusSend && statusEvents != 20'h0);
    cover property (statusSend && statusEvents == 20'h0);
    cover property (shortGo);
endmodule

bind urf_report_level urf_report_level_chk uChk (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .pollTick(pollTick), .statusSend(statusSend),
    .statusEvents(statusEvents), .shortPending(shortPending), .shortGo(shortGo));

// ---- tb/urf_poll_host.sv ----
module urf_poll_host #(parameter int PERIOD = 16) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic statusSend,
    input wire logic [19:0] statusEvents,
    output logic pollTick,
    output int gotCnt,
    output logic [19:0] gotEvents
);
    timeunit 1ns / 1ns;
    int cnt;
    // Polls every interval and keeps the last packet
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= 0;
            pollTick <= 1'b0;
            gotCnt <= 0;
            gotEvents <= 20'h0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            pollTick <= (cnt == PERIOD - 1);
            if (statusSend) gotCnt <= gotCnt + 1;
            if (statusSend) gotEvents <= statusEvents;
        end
    end
endmodule

// ---- tb/urf_report_level_test.sv ----
module urf_report_level_test;
    timeunit 1ns / 1ns;
    logic clk_sys = 0, rst_n = 0, regWr = 0, regRd = 0, shortPending = 0;
    logic [11:0] regAddr = 12'h0;
    logic [31:0] regWrData = 32'h0;
    logic [19:0] eventPulse = 20'h0;
    logic [5:0] fifo = 6'h0;
    wire pollTick, statusSend, shortGo;
    wire [31:0] regRdData;
    wire [19:0] statusEvents, gotEvents;
    int gotCnt, failures = 0, nChecks = 0, n, seen;
    initial forever #25 clk_sys = ~clk_sys;
    urf_report_level DUT (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .eventPulse(eventPulse), .pollTick(pollTick), .statusSend(statusSend),
        .statusEvents(statusEvents), .shortPending(shortPending), .shortGo(shortGo),
        .fifoWrWord(fifo[0]), .fifoWrEnd(fifo[1]), .fifoWrRewind(fifo[2]),
        .fifoRdWord(fifo[3]), .fifoRdEnd(fifo[4]), .fifoRdRewind(fifo[5]));
    urf_poll_host uHost (.clk_sys(clk_sys), .rst_n(rst_n), .statusSend(statusSend),
        .statusEvents(statusEvents), .pollTick(pollTick), .gotCnt(gotCnt),
        .gotEvents(gotEvents));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    // Mask, fire every event, count packets over one poll interval
    task automatic ev(input logic [31:0] m, input int k, input logic [19:0] e);
        wr(12'h068, m);
        // Fire right after a poll so exactly one poll falls in the window
        @(posedge clk_sys iff pollTick);
        eventPulse <= 20'hFFFFF;
        @(posedge clk_sys);
        eventPulse <= 20'h0;
        #1 seen = gotCnt;
        repeat (16) @(posedge clk_sys);
        #1 chk(gotCnt - seen, k);
        if (k > 0) chk(gotEvents, e);
    endtask
    task automatic dly(input logic [15:0] d);
        wr(12'h06C, {16'hFFFF, d});
        rd(12'h06C, {16'h0, d});
        @(posedge clk_sys);
        shortPending <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (shortGo !== 1'b1 && n < 100);
        chk(n, d + 1);
        @(posedge clk_sys);
        shortPending <= 1'b0;
    endtask
    task automatic fop(input logic [5:0] v, input int k);
        repeat (k) begin
            @(posedge clk_sys);
            fifo <= v;
            @(posedge clk_sys);
            fifo <= 6'h0;
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(12'h068, 32'h0);
        rd(12'h06C, 32'h800);
        rd(12'h070, 32'h0);
        rd(12'h0F0, 32'h0);
        wr(12'h068, 32'hFFFFFFFF);
        rd(12'h068, 32'h800FFFFF);
        for (int i = 0; i < 20; i++) ev(32'h1 << i, 1, 20'h1 << i);
        ev(32'h80000000, 1, 20'h0);
        ev(32'h0, 0, 20'h0);
        dly(16'h1);
        dly(16'h5);
        fop(6'h01, 4);
        rd(12'h070, 32'h0000_0004);
        fop(6'h03, 1);
        rd(12'h070, 32'h0005_0005);
        fop(6'h08, 2);
        rd(12'h070, 32'h0003_0005);
        fop(6'h20, 1);
        rd(12'h070, 32'h0005_0005);
        fop(6'h08, 4);
        fop(6'h18, 1);
        rd(12'h070, 32'h0);
        fop(6'h01, 3);
        fop(6'h04, 1);
        rd(12'h070, 32'h0);
        wr(12'h070, 32'hFFFFFFFF);
        rd(12'h070, 32'h0);
        results();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        results();
    end
endmodule
